// ### rtl/lcd_init_pkg.sv
// Behaviour
// R01 - reset low forces display off and normal, non-inverted rendering
// R02 - hardware reset sets segment direction to normal mapping
// R03 - hardware reset clears the three power control bits
// R04 - hardware reset empties the serial interface shift register
// R05 - hardware reset selects one-ninth bias
// R06 - hardware reset cancels line reversal drive and leaves power save
// R07 - hardware reset turns off force-all-pixels-lit
// R08 - hardware reset halts the oscillator until a command restarts it
// R09 - any reset turns static indicator off and clears its two bits
// R10 - any reset leaves read-modify-write mode
// R11 - any reset points display start line to line zero
// R12 - any reset zeroes the column address counter
// R13 - any reset zeroes the page address register
// R14 - any reset sets common scan direction to normal
// R15 - any reset clears the three-bit resistor ratio register
// R16 - any reset leaves contrast set mode, contrast loads midpoint
// R17 - any reset clears line reversal register and leaves test mode
// R18 - software reset applies only items static indicator through test mode
// R19 - host resets after power-up, then drives inputs to defined levels
// R20 - host enters power save before shutting down built-in supply
// R21 - host keeps external supplies off while hardware reset is low
// R22 - status reset flag is one while either reset runs
// R23 - status busy is one during reset; host waits before commanding
// R24 - hardware reset is asynchronous level; commands resume after release (code samples the pin on the clock; only busy follows at once)
package lcd_init_pkg;
   localparam logic [7:0] addr_ctrl   = 8'h00;
   localparam logic [7:0] addr_cfg    = 8'h04;
   localparam logic [7:0] addr_contr  = 8'h08;
   localparam logic [7:0] addr_status = 8'h0c;
   localparam logic [7:0] addr_cmd    = 8'h10;
   localparam logic [7:0] addr_sdata  = 8'h14;

   localparam int soft_reset_time_ns = 20;
   localparam int clock_period_ns    = 4;
   localparam int soft_reset_cycles  =
      (soft_reset_time_ns + clock_period_ns - 1) / clock_period_ns;
   localparam logic [3:0] soft_count_init = 4'(soft_reset_cycles);
   localparam logic [3:0] count_zero      = 4'h0;

   localparam logic [5:0] contrast_reset = 6'h20;
   localparam logic [2:0] power_reset    = 3'h0;
   localparam logic [2:0] ratio_reset    = 3'h0;
   localparam logic [3:0] nline_reset    = 4'h0;
   localparam logic [1:0] static_reset   = 2'h0;
   localparam logic [7:0] col_reset      = 8'h00;
   localparam logic [3:0] page_reset     = 4'h0;
   localparam logic [5:0] start_reset    = 6'h00;
   localparam logic [7:0] shift_reset    = 8'h00;
   localparam logic [2:0] bitcnt_reset   = 3'h0;

   // ctrl register bit positions
   localparam int ctl_disp_on   = 0;
   localparam int ctl_reverse   = 1;
   localparam int ctl_adc_rev   = 2;
   localparam int ctl_all_on    = 3;
   localparam int ctl_bias_7    = 4;
   localparam int ctl_nline_on  = 5;
   localparam int ctl_psave     = 6;
   localparam int ctl_osc_on    = 7;
   localparam int ctl_rmw       = 8;
   localparam int ctl_com_rev   = 9;
   localparam int ctl_ec_mode   = 10;
   localparam int ctl_test      = 11;
   localparam int ctl_static_on = 12;
   // cfg register fields
   localparam int cfg_power_lsb  = 0;
   localparam int cfg_ratio_lsb  = 4;
   localparam int cfg_nline_lsb  = 8;
   localparam int cfg_static_lsb = 12;
   localparam int cfg_start_lsb  = 16;
   localparam int cfg_page_lsb   = 24;
   // status bits
   localparam int st_reset = 4;
   localparam int st_onoff = 5;
   localparam int st_adc   = 6;
   localparam int st_busy  = 7;
   localparam logic [7:0] cmd_soft_reset = 8'he2;

   localparam logic [1:0] resp_okay   = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;

   typedef struct packed {
      logic       disp_on;
      logic       reverse;
      logic       adc_rev;
      logic       all_on;
      logic       bias_7;
      logic       nline_on;
      logic       psave;
      logic       osc_on;
      logic       rmw;
      logic       com_rev;
      logic       ec_mode;
      logic       test;
      logic       static_on;
      logic [1:0] static_bits;
      logic [2:0] power;
      logic [2:0] ratio;
      logic [3:0] nline;
      logic [5:0] contrast;
      logic [5:0] start_line;
      logic [3:0] page;
      logic [7:0] column;
   } settings_type;

   typedef struct packed {
      logic [7:0] data;
      logic [2:0] count;
   } serial_type;

   typedef struct packed {
      logic        aw_got;
      logic        w_got;
      logic [7:0]  aw_addr;
      logic [31:0] w_data;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } bus_type;

   typedef enum logic [1:0] {st_run, st_soft} phase_type;
endpackage

// ### rtl/lcd_init.sv
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module lcd_init (
   input  wire logic                         i_clock,
   input  wire logic                         i_nrst,
   input  wire logic                         i_hw_reset_n,
   input  wire logic                         i_serial_bit_valid,
   input  wire logic                         i_serial_bit,
   input  wire logic [7:0]                   i_awaddr,
   input  wire logic                         i_awvalid,
   output logic                              o_awready,
   input  wire logic [31:0]                  i_wdata,
   input  wire logic [3:0]                   i_wstrb,
   input  wire logic                         i_wvalid,
   output logic                              o_wready,
   output logic [1:0]                        o_bresp,
   output logic                              o_bvalid,
   input  wire logic                         i_bready,
   input  wire logic [7:0]                   i_araddr,
   input  wire logic                         i_arvalid,
   output logic                              o_arready,
   output logic [31:0]                       o_rdata,
   output logic [1:0]                        o_rresp,
   output logic                              o_rvalid,
   input  wire logic                         i_rready,
   output lcd_init_pkg::settings_type        o_settings,
   output logic [7:0]                        o_serial_byte,
   output logic                              o_busy
);
   typedef struct packed {
      lcd_init_pkg::settings_type set;
      lcd_init_pkg::serial_type   ser;
      lcd_init_pkg::bus_type      bus;
      lcd_init_pkg::phase_type    phase;
      logic [3:0]                 count;
      logic [7:0]                 ser_byte;
   } state_type;

   state_type state_reg;
   state_type state_next;
   logic      reset_any;
   logic      wr_fire;
   logic      rd_fire;
   logic [31:0] wval;
   logic [31:0] ctl_word;
   logic [31:0] cfg_word;

   // values forced by either reset: static indicator through test mode
   function automatic lcd_init_pkg::settings_type common_reset(
      input lcd_init_pkg::settings_type s);
      lcd_init_pkg::settings_type r;
      r             = s;
      r.static_on   = 1'b0;                               // R09
      r.static_bits = lcd_init_pkg::static_reset;         // R09
      r.rmw         = 1'b0;                               // R10
      r.start_line  = lcd_init_pkg::start_reset;          // R11
      r.column      = lcd_init_pkg::col_reset;            // R12
      r.page        = lcd_init_pkg::page_reset;           // R13
      r.com_rev     = 1'b0;                               // R14
      r.ratio       = lcd_init_pkg::ratio_reset;          // R15
      r.ec_mode     = 1'b0;                               // R16
      r.contrast    = lcd_init_pkg::contrast_reset;       // R16
      r.nline       = lcd_init_pkg::nline_reset;          // R17
      r.test        = 1'b0;                               // R17
      return r;
   endfunction

   assign reset_any = ~i_hw_reset_n;
   assign wr_fire   = state_reg.bus.aw_got & state_reg.bus.w_got & ~state_reg.bus.bvalid;
   assign rd_fire   = i_arvalid & ~state_reg.bus.rvalid;
   assign wval      = state_reg.bus.w_data;

   always_comb begin
      ctl_word = '0;
      ctl_word[lcd_init_pkg::ctl_disp_on]   = state_reg.set.disp_on;
      ctl_word[lcd_init_pkg::ctl_reverse]   = state_reg.set.reverse;
      ctl_word[lcd_init_pkg::ctl_adc_rev]   = state_reg.set.adc_rev;
      ctl_word[lcd_init_pkg::ctl_all_on]    = state_reg.set.all_on;
      ctl_word[lcd_init_pkg::ctl_bias_7]    = state_reg.set.bias_7;
      ctl_word[lcd_init_pkg::ctl_nline_on]  = state_reg.set.nline_on;
      ctl_word[lcd_init_pkg::ctl_psave]     = state_reg.set.psave;
      ctl_word[lcd_init_pkg::ctl_osc_on]    = state_reg.set.osc_on;
      ctl_word[lcd_init_pkg::ctl_rmw]       = state_reg.set.rmw;
      ctl_word[lcd_init_pkg::ctl_com_rev]   = state_reg.set.com_rev;
      ctl_word[lcd_init_pkg::ctl_ec_mode]   = state_reg.set.ec_mode;
      ctl_word[lcd_init_pkg::ctl_test]      = state_reg.set.test;
      ctl_word[lcd_init_pkg::ctl_static_on] = state_reg.set.static_on;
      cfg_word = '0;
      cfg_word[lcd_init_pkg::cfg_power_lsb +: 3]  = state_reg.set.power;
      cfg_word[lcd_init_pkg::cfg_ratio_lsb +: 3]  = state_reg.set.ratio;
      cfg_word[lcd_init_pkg::cfg_nline_lsb +: 4]  = state_reg.set.nline;
      cfg_word[lcd_init_pkg::cfg_static_lsb +: 2] = state_reg.set.static_bits;
      cfg_word[lcd_init_pkg::cfg_start_lsb +: 6]  = state_reg.set.start_line;
      cfg_word[lcd_init_pkg::cfg_page_lsb +: 4]   = state_reg.set.page;
   end

   always_comb begin
      state_next = state_reg;
      // bus handshakes
      if (i_awvalid & ~state_reg.bus.aw_got) begin
         state_next.bus.aw_got  = 1'b1;
         state_next.bus.aw_addr = i_awaddr;
      end
      if (i_wvalid & ~state_reg.bus.w_got) begin
         state_next.bus.w_got  = 1'b1;
         state_next.bus.w_data = i_wdata & {{8{i_wstrb[3]}}, {8{i_wstrb[2]}},
                                            {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
      end
      if (state_reg.bus.bvalid & i_bready) begin
         state_next.bus.bvalid = 1'b0;
         state_next.bus.aw_got = 1'b0;
         state_next.bus.w_got  = 1'b0;
      end
      if (state_reg.bus.rvalid & i_rready) begin
         state_next.bus.rvalid = 1'b0;
      end
      // serial shift register collects bits msb first
      if (i_serial_bit_valid) begin
         state_next.ser.data  = {state_reg.ser.data[6:0], i_serial_bit};
         state_next.ser.count = state_reg.ser.count + 3'h1;
         if (state_reg.ser.count == 3'h7) begin
            state_next.ser_byte = {state_reg.ser.data[6:0], i_serial_bit};
         end
      end
      // writes are refused with an error during the soft reset window; during the pin reset they answer okay
      if (wr_fire) begin
         state_next.bus.bvalid = 1'b1;
         state_next.bus.bresp  = lcd_init_pkg::resp_okay;
         if (state_reg.phase != lcd_init_pkg::st_run) begin
            state_next.bus.bresp = lcd_init_pkg::resp_slverr; // R23
         end else begin
            case (state_reg.bus.aw_addr)
               lcd_init_pkg::addr_ctrl: begin
                  state_next.set.disp_on   = wval[lcd_init_pkg::ctl_disp_on];
                  state_next.set.reverse   = wval[lcd_init_pkg::ctl_reverse];
                  state_next.set.adc_rev   = wval[lcd_init_pkg::ctl_adc_rev];
                  state_next.set.all_on    = wval[lcd_init_pkg::ctl_all_on];
                  state_next.set.bias_7    = wval[lcd_init_pkg::ctl_bias_7];
                  state_next.set.nline_on  = wval[lcd_init_pkg::ctl_nline_on];
                  state_next.set.psave     = wval[lcd_init_pkg::ctl_psave];
                  state_next.set.osc_on    = wval[lcd_init_pkg::ctl_osc_on];
                  state_next.set.rmw       = wval[lcd_init_pkg::ctl_rmw];
                  state_next.set.com_rev   = wval[lcd_init_pkg::ctl_com_rev];
                  state_next.set.ec_mode   = wval[lcd_init_pkg::ctl_ec_mode];
                  state_next.set.test      = wval[lcd_init_pkg::ctl_test];
                  state_next.set.static_on = wval[lcd_init_pkg::ctl_static_on];
               end
               lcd_init_pkg::addr_cfg: begin
                  state_next.set.power       = wval[lcd_init_pkg::cfg_power_lsb +: 3];
                  state_next.set.ratio       = wval[lcd_init_pkg::cfg_ratio_lsb +: 3];
                  state_next.set.nline       = wval[lcd_init_pkg::cfg_nline_lsb +: 4];
                  state_next.set.static_bits = wval[lcd_init_pkg::cfg_static_lsb +: 2];
                  state_next.set.start_line  = wval[lcd_init_pkg::cfg_start_lsb +: 6];
                  state_next.set.page        = wval[lcd_init_pkg::cfg_page_lsb +: 4];
               end
               lcd_init_pkg::addr_contr: begin
                  state_next.set.contrast = wval[5:0];
                  state_next.set.column   = wval[15:8];
               end
               lcd_init_pkg::addr_cmd: begin
                  if (wval[7:0] == lcd_init_pkg::cmd_soft_reset) begin
                     state_next.phase = lcd_init_pkg::st_soft;          // R18
                     state_next.count = lcd_init_pkg::soft_count_init;
                     state_next.set   = common_reset(state_reg.set);    // R18
                  end
               end
               default: state_next.bus.bresp = lcd_init_pkg::resp_slverr;
            endcase
         end
      end
      // soft reset holds busy for its fixed duration
      case (state_reg.phase)
         lcd_init_pkg::st_run: ;
         lcd_init_pkg::st_soft: begin
            if (state_reg.count == lcd_init_pkg::count_zero) begin
               state_next.phase = lcd_init_pkg::st_run;
            end else begin
               state_next.count = state_reg.count - 4'h1;
            end
         end
         default: state_next.phase = lcd_init_pkg::st_run;
      endcase
      if (rd_fire) begin
         state_next.bus.rvalid = 1'b1;
         state_next.bus.rresp  = lcd_init_pkg::resp_okay;
         state_next.bus.rdata  = '0;
         case (i_araddr)
            lcd_init_pkg::addr_ctrl:   state_next.bus.rdata = ctl_word;
            lcd_init_pkg::addr_cfg:    state_next.bus.rdata = cfg_word;
            lcd_init_pkg::addr_contr:
               state_next.bus.rdata = {16'h0000, state_reg.set.column,
                                       2'h0, state_reg.set.contrast};
            lcd_init_pkg::addr_status: begin
               // both flags also cover the pin reset, not only the command
               state_next.bus.rdata[lcd_init_pkg::st_busy]  =
                  reset_any | (state_reg.phase != lcd_init_pkg::st_run); // R23
               state_next.bus.rdata[lcd_init_pkg::st_reset] =
                  reset_any | (state_reg.phase != lcd_init_pkg::st_run); // R22
               state_next.bus.rdata[lcd_init_pkg::st_onoff] = ~state_reg.set.disp_on;
               state_next.bus.rdata[lcd_init_pkg::st_adc]   = ~state_reg.set.adc_rev;
            end
            lcd_init_pkg::addr_sdata:  state_next.bus.rdata = {24'h000000, state_reg.ser_byte};
            default: state_next.bus.rresp = lcd_init_pkg::resp_slverr;
         endcase
      end
      // hardware reset pin is a level that holds every setting, the shift register and the phase at their initial values
      if (reset_any) begin                                      // R24
         state_next.set          = common_reset(state_reg.set);
         state_next.set.disp_on  = 1'b0;                        // R01
         state_next.set.reverse  = 1'b0;                        // R01
         state_next.set.adc_rev  = 1'b0;                        // R02
         state_next.set.power    = lcd_init_pkg::power_reset;   // R03
         state_next.ser.data     = lcd_init_pkg::shift_reset;   // R04
         state_next.ser.count    = lcd_init_pkg::bitcnt_reset;  // R04
         state_next.set.bias_7   = 1'b0;                        // R05
         state_next.set.nline_on = 1'b0;                        // R06
         state_next.set.psave    = 1'b0;                        // R06
         state_next.set.all_on   = 1'b0;                        // R07
         state_next.set.osc_on   = 1'b0;                        // R08
         state_next.phase        = lcd_init_pkg::st_run;
         state_next.count        = lcd_init_pkg::count_zero;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg                  <= '0;
         state_reg.set.contrast     <= lcd_init_pkg::contrast_reset;
         state_reg.phase            <= lcd_init_pkg::st_run;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_awready     = ~state_reg.bus.aw_got;
   assign o_wready      = ~state_reg.bus.w_got;
   assign o_bvalid      = state_reg.bus.bvalid;
   assign o_bresp       = state_reg.bus.bresp;
   assign o_arready     = ~state_reg.bus.rvalid;
   assign o_rvalid      = state_reg.bus.rvalid;
   assign o_rdata       = state_reg.bus.rdata;
   assign o_rresp       = state_reg.bus.rresp;
   assign o_settings    = state_reg.set;
   assign o_serial_byte = state_reg.ser_byte;
   // busy covers both the pin reset and the soft reset window
   assign o_busy        = reset_any | (state_reg.phase != lcd_init_pkg::st_run); // R23

   hw_reset_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // R01
      !i_hw_reset_n |=> !o_settings.disp_on && !o_settings.osc_on
                        && o_settings.power == 3'h0 && !o_settings.bias_7)
      else $error("hardware reset left a setting active");
   hw_contrast_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // R16
      !i_hw_reset_n |=> o_settings.contrast == 6'h20 && o_settings.column == 8'h00
                        && o_settings.page == 4'h0 && !o_settings.test)
      else $error("reset did not restore contrast or addresses");
   hw_busy_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // R23
      !i_hw_reset_n |-> o_busy)
      else $error("busy low during hardware reset");

   sequence soft_cmd_s;
      wr_fire && state_reg.phase == lcd_init_pkg::st_run && i_hw_reset_n
      && state_reg.bus.aw_addr == lcd_init_pkg::addr_cmd
      && state_reg.bus.w_data[7:0] == lcd_init_pkg::cmd_soft_reset;
   endsequence
   // busy stands while the count runs from five down to zero: six cycles
   sequence soft_busy_s;
      o_busy [*6] ##1 !o_busy;
   endsequence
   soft_busy_a: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_hw_reset_n) // R23
      soft_cmd_s |=> soft_busy_s)
      else $error("soft reset busy window wrong length");
   soft_subset_a: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_hw_reset_n) // R18
      soft_cmd_s |=> o_settings.power == $past(o_settings.power)
                     && o_settings.disp_on == $past(o_settings.disp_on)
                     && o_settings.contrast == 6'h20 && !o_settings.static_on)
      else $error("soft reset touched wrong settings");
   serial_clear_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // R04
      !i_hw_reset_n |=> state_reg.ser.count == 3'h0)
      else $error("serial shift state not cleared");
   run_accept_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // R24
      $rose(i_hw_reset_n) |-> !o_busy)
      else $error("busy after hardware reset release");
   reset_rmw_a: assert property (@(posedge i_clock) disable iff (!i_nrst) // R10
      !i_hw_reset_n |=> !o_settings.rmw && !o_settings.com_rev
                        && o_settings.start_line == 6'h00 && !o_settings.all_on)
      else $error("rmw or scan not reset");
endmodule
`default_nettype wire

// ### dv/lcd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lcd_host_model (
   input  wire logic i_clock,
   input  wire logic i_busy,
   output logic      o_hw_reset_n,
   output logic      o_serial_bit_valid,
   output logic      o_serial_bit,
   output logic      o_ext_supply_on
);
   initial begin
      o_hw_reset_n       = 1'b0;
      o_serial_bit_valid = 1'b0;
      o_serial_bit       = 1'b0;
      o_ext_supply_on    = 1'b0;
   end

   // supplies stay off for the whole time the pin is low
   task automatic pin_reset(input int cycles);
      int n;
      @(posedge i_clock);
      o_ext_supply_on <= 1'b0;
      o_hw_reset_n    <= 1'b0;
      repeat (cycles) @(posedge i_clock);
      o_hw_reset_n <= 1'b1;
      for (n = 0; n < 32; n++) begin
         @(negedge i_clock);
         if (i_busy === 1'b0) break;
      end
      @(posedge i_clock);
      o_ext_supply_on <= 1'b1;
   endtask

   // msb first; the data line is spoiled once valid drops
   task automatic send_bits(input logic [7:0] b, input int count);
      int i;
      for (i = 0; i < count; i++) begin
         @(posedge i_clock);
         o_serial_bit_valid <= 1'b1;
         o_serial_bit       <= b[7 - i];
      end
      @(posedge i_clock);
      o_serial_bit_valid <= 1'b0;
      o_serial_bit       <= ~o_serial_bit;
   endtask
endmodule
`default_nettype wire

// ### dv/lcd_driver_reset_init_bench.sv
`timescale 1ns/100ps
`default_nettype none
module lcd_driver_reset_init_bench;
   typedef struct packed {
      logic        rd;
      logic [31:0] data;
      logic [1:0]  resp;
   } note_type;
   logic                       i_clock = 1'b0;
   logic                       i_nrst, awvalid, wvalid, bready, arvalid, rready;
   logic                       awready, wready, arready, bvalid, rvalid, busy;
   logic                       hw_reset_n, sbit_valid, sbit, ext_on;
   logic [7:0]                 awaddr, araddr, sbyte, sb;
   logic [31:0]                wdata, rdata, cf, ct;
   logic [31:0]                seed = 32'h0000000f;
   logic [1:0]                 bresp, rresp;
   lcd_init_pkg::settings_type settings;
   note_type                   notes[$];
   int                         n_errors = 0;
   int                         comparisons = 0;

   always #2 i_clock = ~i_clock;

   lcd_init i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_hw_reset_n(hw_reset_n),
      .i_serial_bit_valid(sbit_valid), .i_serial_bit(sbit), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .o_settings(settings), .o_serial_byte(sbyte), .o_busy(busy));
   lcd_host_model i_host (.i_clock(i_clock), .i_busy(busy), .o_hw_reset_n(hw_reset_n),
      .o_serial_bit_valid(sbit_valid), .o_serial_bit(sbit), .o_ext_supply_on(ext_on));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic fail(input string what, input logic [33:0] exp, input logic [33:0] got);
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
   endtask

   task automatic timeout();
      fail("handshake", 34'h0, 34'h1);
      final_report();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int   n;
      logic ha, hw, hb;
      notes.push_back({1'b0, d, r});
      @(posedge i_clock);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(negedge i_clock);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid & bready;
         @(posedge i_clock);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) break;
      end
      bready <= 1'b0;
      if (n == 64) timeout();
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int   n;
      logic ha, hb;
      notes.push_back({1'b1, d, r});
      @(posedge i_clock);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(negedge i_clock);
         ha = arvalid & arready;
         hb = rvalid & rready;
         @(posedge i_clock);
         if (ha) arvalid <= 1'b0;
         if (hb) break;
      end
      rready <= 1'b0;
      if (n == 64) timeout();
   endtask

   task automatic check_all(input logic [31:0] c, input logic [31:0] f, input logic [31:0] k);
      axi_read(lcd_init_pkg::addr_ctrl, c, lcd_init_pkg::resp_okay);
      axi_read(lcd_init_pkg::addr_cfg, f, lcd_init_pkg::resp_okay);
      axi_read(lcd_init_pkg::addr_contr, k, lcd_init_pkg::resp_okay);
   endtask

   task automatic wait_idle();
      int n;
      for (n = 0; n < 64; n++) begin
         @(negedge i_clock);
         if (busy === 1'b0) break;
      end
      if (n == 64) timeout();
   endtask

   // answers are matched to notes in the order the requests were made
   always @(negedge i_clock) begin
      note_type e;
      if ((bvalid & bready) | (rvalid & rready)) begin
         e = notes.pop_front();
         comparisons++;
         if (e.rd ? ({rresp, rdata} !== {e.resp, e.data}) : (bresp !== e.resp))
            fail(e.rd ? "read" : "write", {e.resp, e.data},
                 e.rd ? {rresp, rdata} : {bresp, e.data});
      end
      if (i_nrst === 1'b1 && hw_reset_n === 1'b0) begin
         comparisons++;
         if (busy !== 1'b1) fail("busy", 34'h1, {33'h0, busy});
      end
   end

   initial begin
      {i_nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (8) @(posedge i_clock);
      i_nrst <= 1'b1;
      i_host.pin_reset(4);
      check_all(32'h0, 32'h0, 32'h20);
      axi_read(lcd_init_pkg::addr_status, 32'h60, lcd_init_pkg::resp_okay);
      cf = rnd() & 32'h0f3f3f77;
      ct = rnd() & 32'h0000ff3f;
      axi_write(lcd_init_pkg::addr_ctrl, 32'h1fff, lcd_init_pkg::resp_okay);
      axi_write(lcd_init_pkg::addr_cfg, cf, lcd_init_pkg::resp_okay);
      axi_write(lcd_init_pkg::addr_contr, ct, lcd_init_pkg::resp_okay);
      check_all(32'h1fff, cf, ct);
      axi_write(lcd_init_pkg::addr_cmd, {24'h0, lcd_init_pkg::cmd_soft_reset},
         lcd_init_pkg::resp_okay);
      axi_read(lcd_init_pkg::addr_status, 32'h90, lcd_init_pkg::resp_okay);
      wait_idle();
      check_all(32'h00ff, cf & 32'h7, 32'h20);
      sb = 8'(rnd());
      i_host.send_bits(~sb, 5);
      axi_write(lcd_init_pkg::addr_ctrl, 32'h1fff, lcd_init_pkg::resp_okay);
      axi_write(lcd_init_pkg::addr_cfg, cf | 32'h0f3f3f77, lcd_init_pkg::resp_okay);
      // status is read while the pin is still low
      fork
         i_host.pin_reset(3);
         axi_read(lcd_init_pkg::addr_status, 32'h90, lcd_init_pkg::resp_okay);
      join
      check_all(32'h0, 32'h0, 32'h20);
      i_host.send_bits(sb, 8);
      axi_read(lcd_init_pkg::addr_sdata, {24'h0, sb}, lcd_init_pkg::resp_okay);
      axi_read(8'h18, 32'h0, lcd_init_pkg::resp_slverr);
      axi_write(8'h18, 32'h0, lcd_init_pkg::resp_slverr);
      // supply shutdown: power save first, then the stages off
      axi_write(lcd_init_pkg::addr_cfg, 32'h7, lcd_init_pkg::resp_okay);
      axi_write(lcd_init_pkg::addr_ctrl, 32'h40, lcd_init_pkg::resp_okay);
      axi_write(lcd_init_pkg::addr_cfg, 32'h0, lcd_init_pkg::resp_okay);
      axi_read(lcd_init_pkg::addr_cfg, 32'h0, lcd_init_pkg::resp_okay);
      final_report();
   end
endmodule
`default_nettype wire
